// ### logic/lcdd_pkg.sv
// lcdd_pkg: frame layout, latched fields, decoded drive set, APB map
// assumes: one 10 MHz APB clock, frame bits arrive first-bit-first
//
// Behaviour
// RULE1 - latch frame only on device code match, at frame enable fall
// RULE2 - host sends 160 bits: code 8, data 149, direction 3
// RULE3 - static frame: 70 display bits then all control fields; here the key split code is sent before the display bits
// RULE4 - key split code hands six shared pins to strobes, 5 keys each
// RULE5 - port count n makes first n pins ports; over 9 none
// RULE6 - per-pin select 0 picks PWM, reset 0
// RULE7 - per-pin select 1 picks general-purpose output
// RULE8 - pin k takes display bit (k-1)*N+1, N from duty
// RULE9 - general-purpose pin drives its mapped display bit steadily
// RULE10 - inversion bit: 0 line, 1 frame, reset 0
// RULE11 - bias: 00 third, 01 full, 10 quarter, 11 half
// RULE12 - duty code decode, 110 and 111 mean quarter duty
// RULE13 - frame rate code picks oscillator divider 12288 down to 1536
// RULE14 - first sent bit of a field is its MSB
// RULE15 - oscillator select: 0 internal, 1 external on shared pin
// RULE16 - host starts external clock only after the switching frame
// RULE17 - blank bit 1 forces segment-off waveforms, reset 1
// RULE18 - power code 000 normal, anything else power saving
// RULE19 - standby strobe levels follow the power code
// RULE20 - power saving keeps only GPO, holds segments and commons low
// RULE21 - frames still latch during power saving
package lcdd_pkg;

  localparam int FRAME_BITS   = 160;
  localparam int CODE_BITS    = 8;
  localparam int DATA_BITS    = 149;
  localparam int DIR_BITS     = 3;
  localparam int CFG_BITS     = 101;
  localparam int CFG_MSB      = FRAME_BITS - CODE_BITS - 1;
  localparam int CFG_LSB      = CFG_MSB - CFG_BITS + 1;
  localparam int DISP_BITS    = 70;
  localparam int KEY_PINS     = 6;
  localparam int KEYS_PER_PIN = 5;
  localparam int MF_PINS      = 9;
  localparam int CNT_W        = 8;

  // ---------------------------------------------------------------
  // apb map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_CFG   = 8'h04;
  localparam logic [7:0] ADDR_DISP0 = 8'h08;
  localparam logic [7:0] ADDR_DISP1 = 8'h0C;
  localparam logic [7:0] ADDR_DISP2 = 8'h10;
  localparam logic [7:0] ADDR_STAT  = 8'h14;
  localparam logic       CTRL_RST   = 1'b1;

  typedef enum logic [2:0] {
    DUTY_STATIC, DUTY_1_3, DUTY_1_4, DUTY_1_5, DUTY_1_7, DUTY_1_8
  } lcdd_duty_t;
  typedef enum logic [1:0] {
    BIAS_1_3, BIAS_1_1, BIAS_1_4, BIAS_1_2
  } lcdd_bias_t;
  typedef enum logic {INV_LINE, INV_FRAME} lcdd_inv_t;

  // field order is transmission order, first bit is the MSB
  typedef struct packed {
    logic [2:0]  keyscan_pin_split;
    logic [69:0] display_bits;
    logic [3:0]  port_function_count;
    logic        inversion_select;
    logic [1:0]  bias_select;
    logic [2:0]  duty_select;
    logic [3:0]  frame_rate_select;
    logic        osc_source_select;
    logic        segment_blank;
    logic [2:0]  power_save_select;
    logic [8:0]  port_pwm_or_gpo_select;
  } lcdd_cfg_t;

  localparam lcdd_cfg_t CFG_RST = '{
    keyscan_pin_split: 3'h7, display_bits: 70'h0,
    port_function_count: 4'hF, inversion_select: 1'h0,
    bias_select: 2'h0, duty_select: 3'h2, frame_rate_select: 4'h0,
    osc_source_select: 1'h0, segment_blank: 1'h1,
    power_save_select: 3'h7, port_pwm_or_gpo_select: 9'h000};

  typedef struct packed {
    logic [5:0]  strobe_pin_mask;
    logic [4:0]  key_count;
    logic [5:0]  ks_standby_level;
    logic [8:0]  mf_port;
    logic [8:0]  mf_gpo_en;
    logic [8:0]  mf_pwm_en;
    logic [8:0]  mf_seg_en;
    logic [8:0]  mf_gpo_level;
    lcdd_inv_t   inversion;
    lcdd_bias_t  bias;
    lcdd_duty_t  duty;
    logic [13:0] frame_div;
    logic        osc_ext;
    logic        osc_run;
    logic        seg_blank;
    logic        seg_force_low;
    logic        com_force_low;
    logic        bias_gen_on;
  } lcdd_out_t;

  localparam lcdd_out_t OUT_RST = '{
    strobe_pin_mask: 6'h00, key_count: 5'h00,
    ks_standby_level: 6'h3F, mf_port: 9'h000, mf_gpo_en: 9'h000,
    mf_pwm_en: 9'h000, mf_seg_en: 9'h000, mf_gpo_level: 9'h000,
    inversion: INV_LINE, bias: BIAS_1_3, duty: DUTY_1_4,
    frame_div: 14'h3000, osc_ext: 1'h0, osc_run: 1'h0,
    seg_blank: 1'h1, seg_force_low: 1'h1, com_force_low: 1'h1,
    bias_gen_on: 1'h0};

  function automatic logic [13:0] frame_div(input logic [3:0] rate_code);
    case (rate_code)
      4'h0: return 14'h3000;
      4'h1: return 14'h2A00;
      4'h2: return 14'h2400;
      4'h3: return 14'h1E00;
      4'h4: return 14'h1800;
      4'h5: return 14'h1200;
      4'h6: return 14'h0F00;
      4'h7: return 14'h0C00;
      4'h8: return 14'h0B40;
      4'h9: return 14'h0A80;
      4'hA: return 14'h09C0;
      4'hB: return 14'h0900;
      4'hC: return 14'h0840;
      4'hD: return 14'h0780;
      4'hE: return 14'h06C0;
      default: return 14'h0600;
    endcase
  endfunction

endpackage

// ### logic/lcdd_frame_rx.sv
// lcdd_frame_rx: samples the three-wire link on pclk, shifts bits
// assumes: link clock far slower than pclk, bits taken on its rise
`timescale 1ns/10ps
`default_nettype none
module lcdd_frame_rx
  import lcdd_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  shift_clock,
  input  wire logic                  serial_frame_enable,
  input  wire logic                  shift_data_in,
  output logic                       frame_done,
  output logic [FRAME_BITS-1:0]      frame
);

  logic [1:0]       clk_s;
  logic [1:0]       en_s;
  logic [1:0]       dat_s;
  logic             clk_d;
  logic             en_d;
  logic [CNT_W-1:0] bit_cnt;

  // ---------------------------------------------------------------
  // synchronisers, edges found after the second stage only
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_s <= 2'h0;
      en_s  <= 2'h0;
      dat_s <= 2'h0;
      clk_d <= 1'b0;
      en_d  <= 1'b0;
    end else begin
      clk_s <= {clk_s[0], shift_clock};
      en_s  <= {en_s[0], serial_frame_enable};
      dat_s <= {dat_s[0], shift_data_in};
      clk_d <= clk_s[1];
      en_d  <= en_s[1];
    end
  end

  wire clk_rise = clk_s[1] & ~clk_d;
  wire en_fall  = en_d & ~en_s[1];
  wire bit_take = clk_rise & en_s[1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame   <= '0;
      bit_cnt <= '0;
    end else if (bit_take) begin
      frame   <= {frame[FRAME_BITS-2:0], dat_s[1]};
      // saturate so an over-long frame never wraps back to 160
      if (bit_cnt != '1) bit_cnt <= bit_cnt + 1'b1;
    end else if (!en_s[1]) begin
      bit_cnt <= '0;
    end
  end

  // short or long frames are dropped, not latched half-shifted
  assign frame_done = en_fall & (bit_cnt == CNT_W'(FRAME_BITS)); // [RULE2]

endmodule
`default_nettype wire

// ### logic/lcdd_ctrl.sv
// lcdd_ctrl: latches control frames, decodes drive settings, apb view
// assumes: apb master at pclk, link pins asynchronous to pclk
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module lcdd_ctrl
  import lcdd_pkg::*;
#(
  parameter logic [7:0] DEVICE_CODE = 8'hA5 // arbitrary value
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        shift_clock,
  input  wire logic        serial_frame_enable,
  input  wire logic        shift_data_in,
  output var lcdd_out_t    drive_cfg
);

  logic                  frame_done;
  logic [FRAME_BITS-1:0] frame;
  lcdd_cfg_t             cfg;
  lcdd_out_t             next_out;
  logic                  rx_enable;
  logic [15:0]           frame_count;
  logic                  rejected;

  lcdd_frame_rx u_rx (
    .pclk                (pclk),
    .presetn             (presetn),
    .shift_clock         (shift_clock),
    .serial_frame_enable (serial_frame_enable),
    .shift_data_in       (shift_data_in),
    .frame_done          (frame_done),
    .frame               (frame)
  );

  // ---------------------------------------------------------------
  // frame latch
  // ---------------------------------------------------------------
  wire [7:0] rx_code = frame[FRAME_BITS-1 -: CODE_BITS];
  wire       code_ok = rx_code == DEVICE_CODE;
  wire       take    = frame_done & code_ok & rx_enable; // [RULE1]
  wire lcdd_cfg_t rx_cfg = lcdd_cfg_t'(frame[CFG_MSB:CFG_LSB]);

  // power state never gates the latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cfg <= CFG_RST;
    else if (take) cfg <= rx_cfg; // [RULE1] [RULE3] [RULE14] [RULE21]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_count <= 16'h0000;
      rejected    <= 1'b0;
    end else if (frame_done) begin
      if (take) frame_count <= frame_count + 16'h0001;
      rejected <= ~code_ok;
    end
  end

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic int duty_step(input logic [2:0] code);
    case (code)
      3'h0: return 1;
      3'h1: return 3;
      3'h3: return 5;
      3'h4: return 7;
      3'h5: return 8;
      default: return 4;
    endcase
  endfunction

  function automatic logic gpo_bit(input lcdd_cfg_t c, input int k);
    int idx;
    idx = DISP_BITS - 1 - k * duty_step(c.duty_select);
    return c.display_bits[idx];
  endfunction

  wire [2:0] split    = cfg.keyscan_pin_split;
  wire [2:0] seg_pins = (split > 3'h6) ? 3'h6 : split; // [RULE4]
  wire [2:0] ps       = cfg.power_save_select;
  wire       psave    = ps != 3'h0; // [RULE18]
  wire [2:0] low_pins = (ps >= 3'h1 && ps <= 3'h5) ?
                        3'(KEY_PINS - int'(ps)) : 3'h0; // [RULE19]
  wire [3:0] pc       = cfg.port_function_count;
  wire [3:0] port_n   = (pc <= 4'h9) ? pc : 4'h0; // [RULE5]
  wire [8:0] pin_sel  = cfg.port_pwm_or_gpo_select;

  logic [5:0] strobe_mask;
  logic [5:0] standby;
  logic [8:0] mf_port;
  logic [8:0] mf_gpo;
  logic [8:0] mf_lvl;

  genvar gj;
  generate
    for (gj = 0; gj < KEY_PINS; gj++) begin : g_key
      assign strobe_mask[gj] = 3'(gj) >= seg_pins; // [RULE4]
      assign standby[gj]     = 3'(gj) >= low_pins; // [RULE19]
    end
    for (gj = 0; gj < MF_PINS; gj++) begin : g_mf
      assign mf_port[gj] = 4'(gj) < port_n; // [RULE5]
      // select bits are sent pin 1 first, so pin k is at 9-k
      assign mf_gpo[gj]  = mf_port[gj] & pin_sel[MF_PINS-1-gj]; // [RULE7]
      assign mf_lvl[gj]  = gpo_bit(cfg, gj); // [RULE8]
    end
  endgenerate

  always_comb begin
    next_out                  = OUT_RST;
    next_out.strobe_pin_mask  = strobe_mask;
    next_out.key_count        =
      5'((KEY_PINS - int'(seg_pins)) * KEYS_PER_PIN); // [RULE4]
    next_out.ks_standby_level = standby;
    next_out.mf_port          = mf_port;
    // gpo stays live in power saving, pwm and segment do not
    next_out.mf_gpo_en        = mf_gpo; // [RULE20]
    next_out.mf_pwm_en        = psave ? 9'h000
                                : mf_port & ~mf_gpo; // [RULE6]
    next_out.mf_seg_en        = psave ? 9'h000 : ~mf_port;
    next_out.mf_gpo_level     = mf_lvl & mf_gpo; // [RULE9]
    next_out.inversion        =
      lcdd_inv_t'(cfg.inversion_select); // [RULE10]
    next_out.bias             =
      lcdd_bias_t'(cfg.bias_select); // [RULE11]
    case (cfg.duty_select) // [RULE12]
      3'h0: next_out.duty = DUTY_STATIC;
      3'h1: next_out.duty = DUTY_1_3;
      3'h3: next_out.duty = DUTY_1_5;
      3'h4: next_out.duty = DUTY_1_7;
      3'h5: next_out.duty = DUTY_1_8;
      default: next_out.duty = DUTY_1_4;
    endcase
    next_out.frame_div = frame_div(cfg.frame_rate_select); // [RULE13]
    next_out.osc_ext   = cfg.osc_source_select; // [RULE15]
    next_out.osc_run   = ~psave; // [RULE18]
    next_out.seg_blank = cfg.segment_blank; // [RULE17]
    next_out.seg_force_low = psave; // [RULE20]
    next_out.com_force_low = psave; // [RULE20]
    next_out.bias_gen_on   = ~psave; // [RULE20]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) drive_cfg <= OUT_RST;
    else drive_cfg <= next_out;
  end

  // ---------------------------------------------------------------
  // apb slave, zero wait states
  // ---------------------------------------------------------------
  wire addr_ok = paddr inside {ADDR_CTRL, ADDR_CFG, ADDR_DISP0,
                               ADDR_DISP1, ADDR_DISP2, ADDR_STAT};
  wire apb_setup = psel & ~penable;
  wire apb_wr    = psel & penable & pwrite & (paddr == ADDR_CTRL);
  wire [30:0] cfg_word = {cfg.keyscan_pin_split,
    cfg.port_function_count, cfg.inversion_select, cfg.bias_select,
    cfg.duty_select, cfg.frame_rate_select, cfg.osc_source_select,
    cfg.segment_blank, cfg.power_save_select, pin_sel};
  wire [31:0] rd_word =
    (paddr == ADDR_CTRL)  ? {31'h0, rx_enable} :
    (paddr == ADDR_CFG)   ? {1'b0, cfg_word} :
    (paddr == ADDR_DISP0) ? cfg.display_bits[69:38] :
    (paddr == ADDR_DISP1) ? cfg.display_bits[37:6] :
    (paddr == ADDR_DISP2) ? {26'h0, cfg.display_bits[5:0]} :
    (paddr == ADDR_STAT)  ? {15'h0, rejected, frame_count} : 32'h0;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata    <= 32'h0;
      rx_enable <= CTRL_RST;
    end else begin
      if (apb_setup) prdata <= rd_word;
      if (apb_wr) rx_enable <= pwdata[0];
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_LATCH_MATCH: assert property ( // [RULE1] [RULE21]
    take |=> cfg == $past(rx_cfg))
    else $error("matching frame not latched");
  AST_NO_LATCH_MISMATCH: assert property ( // [RULE1]
    (frame_done && !code_ok) |=> $stable(cfg))
    else $error("foreign frame changed settings");
  AST_DISPLAY_FIELD: assert property ( // [RULE3]
    take |=> cfg.display_bits == $past(frame[CFG_MSB-3 -: 70]))
    else $error("display field misplaced");
  AST_KEYS_ALL: assert property ( // [RULE4]
    split == 3'h0 |=> drive_cfg.key_count == 5'h1E
                   && drive_cfg.strobe_pin_mask == 6'h3F)
    else $error("code 000 must give 30 keys");
  AST_KEYS_NONE: assert property ( // [RULE4]
    split[2:1] == 2'h3 |=> drive_cfg.key_count == 5'h00
                        && drive_cfg.strobe_pin_mask == 6'h00)
    else $error("codes 110/111 must give 0 keys");
  AST_PORT_COUNT: assert property ( // [RULE5]
    pc > 4'h9 |=> drive_cfg.mf_port == 9'h000 ##0
      drive_cfg.mf_seg_en == {9{~$past(psave)}})
    else $error("port code above 9 must leave segments");
  AST_PWM_GPO_EXCL: assert property ( // [RULE6] [RULE7]
    (drive_cfg.mf_gpo_en & drive_cfg.mf_pwm_en) == 9'h000
      && (!drive_cfg.osc_run || drive_cfg.mf_port
          == (drive_cfg.mf_gpo_en | drive_cfg.mf_pwm_en)))
    else $error("port pin not exactly one of pwm and gpo");
  AST_GPO_BIT65: assert property ( // [RULE8] [RULE9]
    (cfg.duty_select == 3'h5 && pc == 4'h9 && pin_sel[0])
      |=> drive_cfg.mf_gpo_level[8] == $past(cfg.display_bits[5]))
    else $error("pin 9 at 1/8 duty must follow bit 65");
  AST_GPO_BIT57: assert property ( // [RULE8]
    (cfg.duty_select == 3'h4 && pc == 4'h9 && pin_sel[0])
      |=> drive_cfg.mf_gpo_level[8] == $past(cfg.display_bits[13]))
    else $error("pin 9 at 1/7 duty must follow bit 57");
  AST_MODE_BITS: assert property ( // [RULE10] [RULE15] [RULE17]
    take |=> ##1 drive_cfg.osc_ext == $past(rx_cfg.osc_source_select, 2)
      && drive_cfg.seg_blank == $past(rx_cfg.segment_blank, 2)
      && drive_cfg.inversion == $past(rx_cfg.inversion_select, 2))
    else $error("mode bits not passed on in two cycles");
  AST_BIAS: assert property ( // [RULE11]
    cfg.bias_select == 2'h1 |=> drive_cfg.bias == BIAS_1_1)
    else $error("bias 01 must be full bias");
  AST_DUTY_SPARE: assert property ( // [RULE12]
    cfg.duty_select[2:1] == 2'h3 |=> drive_cfg.duty == DUTY_1_4)
    else $error("duty 110/111 must be quarter");
  AST_DIV: assert property ( // [RULE13]
    cfg.frame_rate_select == 4'hF |=> drive_cfg.frame_div == 14'h0600)
    else $error("frame rate code 1111 must divide by 1536");
  AST_POWER_SAVE: assert property ( // [RULE18] [RULE20]
    psave |=> !drive_cfg.osc_run && drive_cfg.com_force_low
      && drive_cfg.seg_force_low && !drive_cfg.bias_gen_on
      && drive_cfg.mf_pwm_en == 9'h000)
    else $error("power saving state incomplete");
  AST_STANDBY: assert property ( // [RULE19]
    ps == 3'h1 |=> drive_cfg.ks_standby_level == 6'h20)
    else $error("power code 001 must drive five strobes low");

  COV_TAKE: cover property (take);
  COV_TAKE_PSAVE: cover property (take && psave);
  COV_MISMATCH: cover property (frame_done && !code_ok);
  COV_APB_WR: cover property (apb_wr);

endmodule
`default_nettype wire

// ### test/lcdd_host_model.sv
// lcdd_host_model: host end of the three-wire frame link
// assumes: bench calls send_frame by hierarchical reference
`timescale 1ns/10ps
`default_nettype none
module lcdd_host_model
  import lcdd_pkg::*;
(
  output logic shift_clock,
  output logic serial_frame_enable,
  output logic shift_data_in
);
  localparam int HALF_NS = 400;

  initial begin
    shift_clock         = 1'b0;
    serial_frame_enable = 1'b0;
    shift_data_in       = 1'b1;
  end

  // ---------------------------------------------------------------
  // frame sender
  // ---------------------------------------------------------------
  // nbits short of a full frame only for refusal cases
  task automatic send_frame(input logic [FRAME_BITS-1:0] f,
                            input int nbits);
    #137;
    serial_frame_enable = 1'b1;
    for (int i = 0; i < nbits; i++) begin
      shift_data_in = f[FRAME_BITS-1-i]; // first bit out is msb
      #(HALF_NS);
      shift_clock = 1'b1;
      #(HALF_NS);
      shift_clock = 1'b0;
    end
    #(HALF_NS);
    serial_frame_enable = 1'b0;
    // released line flips so a stale bit never looks valid
    shift_data_in = ~shift_data_in;
    #(4*HALF_NS);
  endtask
  // no external clock is ever driven ahead of a frame
endmodule
`default_nettype wire

// ### test/tb.sv
// tb: frame latch, decode and apb view of lcdd_ctrl
// assumes: lcdd_host_model on the link, apb master here
`timescale 1ns/10ps
`default_nettype none
module tb;
  import lcdd_pkg::*;
  localparam logic [7:0] DEV = 8'h3C; // arbitrary value
  localparam logic [13:0] DIVS [16] = '{14'h3000, 14'h2A00, 14'h2400,
    14'h1E00, 14'h1800, 14'h1200, 14'h0F00, 14'h0C00, 14'h0B40, 14'h0A80,
    14'h09C0, 14'h0900, 14'h0840, 14'h0780, 14'h06C0, 14'h0600};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [31:0] seed = 32'h5599FEDF;
  logic [15:0] count = 16'h0000;
  logic        prev_ok = 1'b0;
  wire         shift_clock, serial_frame_enable, shift_data_in;
  lcdd_out_t   drive_cfg, prev;
  lcdd_cfg_t   c, bad;
  lcdd_out_t   out_q[$];
  logic [32:0] rd_q[$];
  int          fails = 0;
  int          cmp_count = 0;

  lcdd_ctrl #(.DEVICE_CODE(DEV)) lcdd_ctrl_inst (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .shift_clock(shift_clock),
    .serial_frame_enable(serial_frame_enable),
    .shift_data_in(shift_data_in), .drive_cfg(drive_cfg));
  lcdd_host_model lcdd_host_model_inst (.shift_clock(shift_clock),
    .serial_frame_enable(serial_frame_enable),
    .shift_data_in(shift_data_in));

  // ---------------------------------------------------------------
  // reference model
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic lcdd_out_t model(input lcdd_cfg_t x);
    lcdd_out_t o;
    int        k, n, b, nd;
    logic      run;
    o = '0;
    k = x.keyscan_pin_split;
    n = x.port_function_count;
    b = x.power_save_select;
    run = (b == 0);
    o.strobe_pin_mask = (k < 6) ? 6'h3F << k : 6'h00;
    o.key_count = (k < 6) ? 5'(30 - 5 * k) : 5'h00;
    o.ks_standby_level =
      (b >= 1 && b <= 5) ? 6'h3F << (6 - b) : 6'h3F;
    o.mf_port = (n <= 9) ? 9'((1 << n) - 1) : 9'h000;
    case (x.duty_select)
      3'h0: nd = 1;
      3'h1: nd = 3;
      3'h3: nd = 5;
      3'h4: nd = 7;
      3'h5: nd = 8;
      default: nd = 4;
    endcase
    for (int p = 0; p < 9; p++) begin
      o.mf_gpo_en[p] = o.mf_port[p] & x.port_pwm_or_gpo_select[8-p];
      o.mf_gpo_level[p] =
        o.mf_gpo_en[p] & x.display_bits[69-p*nd];
    end
    o.mf_pwm_en = o.mf_port & ~o.mf_gpo_en & {9{run}};
    o.mf_seg_en = ~o.mf_port & {9{run}};
    o.inversion = lcdd_inv_t'(x.inversion_select);
    o.bias = lcdd_bias_t'(x.bias_select);
    o.duty = (x.duty_select > 5) ? DUTY_1_4
             : lcdd_duty_t'(x.duty_select);
    o.frame_div = DIVS[x.frame_rate_select];
    o.osc_ext = x.osc_source_select;
    o.osc_run = run;
    o.seg_blank = x.segment_blank;
    o.seg_force_low = !run;
    o.com_force_low = !run;
    o.bias_gen_on = run;
    return o;
  endfunction

  // external clock only tried while saving, so osc_run stays plain
  function automatic lcdd_cfg_t rand_cfg(input int i);
    lcdd_cfg_t r;
    r = 101'({rnd(), rnd(), rnd(), rnd()});
    r.keyscan_pin_split = 3'(i);
    r.port_function_count = 4'(i);
    r.bias_select = 2'(i);
    r.duty_select = 3'(i * 5);
    r.frame_rate_select = 4'(i);
    r.power_save_select = 3'(i >> 1);
    r.port_pwm_or_gpo_select[0] = 1'(i);
    if (r.power_save_select == 3'h0) r.osc_source_select = 1'b0;
    // last frame reaches the 1/7 duty mapping of pin 9
    if (i == 15) begin
      r.port_function_count = 4'h9;
      r.duty_select = 3'h4;
    end
    return r;
  endfunction

  function automatic logic [31:0] cfg_word(input lcdd_cfg_t x);
    return {1'b0, x.keyscan_pin_split, x.port_function_count,
            x.inversion_select, x.bias_select, x.duty_select,
            x.frame_rate_select, x.osc_source_select, x.segment_blank,
            x.power_save_select, x.port_pwm_or_gpo_select};
  endfunction

  // ---------------------------------------------------------------
  // drivers and checks
  // ---------------------------------------------------------------
  task automatic cmp(input string nm, input logic [32:0] e,
                     input logic [32:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic cmp_out(input lcdd_out_t e, input lcdd_out_t g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] drive_cfg exp %h got %h", e, g);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(a, 1'b0, rnd());
  endtask

  task automatic check_regs(input logic rej);
    rd(ADDR_CFG, {1'b0, cfg_word(c)});
    rd(ADDR_DISP0, {1'b0, c.display_bits[69:38]});
    rd(ADDR_DISP1, {1'b0, c.display_bits[37:6]});
    rd(ADDR_DISP2, {27'h0, c.display_bits[5:0]});
    rd(ADDR_STAT, {16'h0, rej, count});
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // any decode change must match the oldest note; none pending is a fail
  always @(posedge pclk) begin
    if (prev_ok && presetn && drive_cfg !== prev) begin
      cmp_out(out_q.size() > 0 ? out_q.pop_front() : 'x, drive_cfg);
    end
    if (psel && penable && pready && !pwrite) begin
      cmp("apb_read", rd_q.size() > 0 ? rd_q.pop_front() : 'x,
          {pslverr, prdata});
    end
    prev <= drive_cfg;
    prev_ok <= presetn;
  end

  // ---------------------------------------------------------------
  // clock, watchdog, sequence
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    #6000000;
    fails++;
    stop_test();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    paddr = 8'h00;
    pwrite = 1'b0;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // sample once the first decode after reset has settled
    @(negedge pclk);
    cmp_out(model(CFG_RST), drive_cfg);
    c = CFG_RST;
    rd(ADDR_CTRL, 33'h1);
    check_regs(1'b0);
    for (int i = 0; i < 16; i++) begin
      c = rand_cfg(i);
      out_q.push_back(model(c));
      lcdd_host_model_inst.send_frame({DEV, c, 48'(rnd()), 3'(rnd())},
                                      FRAME_BITS);
      count++;
      repeat (12) @(posedge pclk);
      check_regs(1'b0);
    end
    bad = rand_cfg(3);
    lcdd_host_model_inst.send_frame({~DEV, bad, 51'h0}, FRAME_BITS);
    repeat (12) @(posedge pclk);
    check_regs(1'b1);
    lcdd_host_model_inst.send_frame({DEV, bad, 51'h0}, FRAME_BITS - 1);
    repeat (12) @(posedge pclk);
    rd(ADDR_CFG, {1'b0, cfg_word(c)});
    apb(ADDR_CTRL, 1'b1, 32'h0);
    rd(ADDR_CTRL, 33'h0);
    lcdd_host_model_inst.send_frame({DEV, bad, 51'h0}, FRAME_BITS);
    repeat (12) @(posedge pclk);
    rd(ADDR_CFG, {1'b0, cfg_word(c)});
    apb(ADDR_CTRL, 1'b1, 32'h1);
    apb(ADDR_CFG, 1'b1, rnd());
    rd(ADDR_CFG, {1'b0, cfg_word(c)});
    rd(8'h18, {1'b1, 32'h0});
    repeat (4) @(posedge pclk);
    cmp("pending", 33'h0, 33'(out_q.size() + rd_q.size()));
    stop_test();
  end
endmodule
`default_nettype wire
